/* File: inc/ja_clock_pkg.sv */
// constants for the jitter attenuation clock mode block
// assumes a 40 MHz system clock and software access over Avalon-MM
// Notes on behaviour
// [RL1] two pins pick system-bus synchronous, line synchronous or free-run mode
// [RL2] system-bus mode takes clock and frame pins as inputs, else drives them
// [RL3] system-bus mode dejitters the supplied system clock and times transmit from it
// [RL4] line mode dejitters recovered clock, drives it out, times transmit from it
// [RL5] recovered line clock always goes raw to the extracted clock output
// [RL6] free-run times transmit from internal clock and drives it on clock pin
// [RL7] system-bus normal T1 uses the transmit slip buffer between clocks
// [RL8] T1 inverse mux skips slip buffer, routes transmit through the FIFO
// [RL9] E1 system-bus mode always routes transmit through the FIFO
// [RL10] FIFO written on incoming system clock, read on dejittered clock
// [RL11] FIFO depth 16 to 128 two-bit words in steps of 16
// [RL12] toggling the centre control bit re-centres the read pointer
// [RL13] read pointer within 4 bits of an end shifts read rate 1/16 UI
// [RL14] centring ends within 3904 ns per word, no attenuation meanwhile
// [RL15] T1 inverse mux enables no slip buffer, signalling or HDLC
// [RL16] T1 inverse mux: 1.544 MHz clock writes FIFO, clean clock reads it
// [RL17] E1 inverse mux: slip buffers bypassed, 2.048 MHz clock writes FIFO
// [RL18] inverse mux sends recovered clock and data straight out undejittered
// [RL19] controller sets both mode pins high before using inverse mux
// [RL20] PLL locks to the 4.096 MHz input clock or the recovered line clock
// [RL21] depth setting is three bits, depth/16-1, reset to maximum
package ja_clock_pkg;
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned CLK_NS       = 25;
  localparam int unsigned FREE_HZ      = 4_096_000;
  localparam int unsigned PER_FRAC     = 4;
  localparam logic [11:0] FREE_PER_X16 = 12'(CLK_HZ * 16 / FREE_HZ);
  localparam logic [11:0] PER_MAX      = 12'hfff;
  localparam int unsigned CENTER_NS_PER_WORD  = 3904;
  localparam int unsigned CENTER_CYC_PER_WORD = CENTER_NS_PER_WORD / CLK_NS;
  localparam logic [8:0]  EDGE_GUARD   = 9'h004;
  localparam int unsigned FRAME_TICKS  = 512;
  localparam logic [2:0]  DEPTH_SEL_RST = 3'h7;
  localparam int unsigned ARRAY_BITS   = 256;
  // register byte addresses
  localparam logic [3:0]  ADDR_CTRL    = 4'h0;
  localparam logic [3:0]  ADDR_STATUS  = 4'h4;
  // control fields
  localparam int unsigned CTRL_E1      = 0;
  localparam int unsigned CTRL_IMA     = 1;
  localparam int unsigned CTRL_DEPTH_LO = 2;
  localparam int unsigned CTRL_CENTER  = 5;
  // status fields
  localparam int unsigned ST_MODE_LO   = 0;
  localparam int unsigned ST_CENTERING = 3;
  localparam int unsigned ST_FIFO_PATH = 4;
  localparam int unsigned ST_SLIP_ON   = 5;
  localparam int unsigned ST_LEVEL_LO  = 8;

  typedef enum logic [2:0] {
    MODE_SYSBUS = 3'b001,
    MODE_LINE   = 3'b010,
    MODE_FREE   = 3'b100
  } clk_mode_t;
endpackage

/* File: design/ja_clock_mode.sv */
// jitter attenuation clock mode selection, clean clock generator and FIFO
// assumes every pin input is asynchronous to clk_sys and sampled here
`default_nettype none
module ja_clock_mode #(
  parameter int unsigned CENTER_CYC_PER_WORD = ja_clock_pkg::CENTER_CYC_PER_WORD,
  parameter int unsigned FRAME_TICKS         = ja_clock_pkg::FRAME_TICKS
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        bus_or_line_select,
  input  wire logic        sync_or_freerun_select,
  input  wire logic        system_clock_pin_in,
  output logic             system_clock_pin_out,
  output logic             system_clock_pin_oe_b,
  input  wire logic        frame_pulse_pin_in,
  output logic             frame_pulse_pin_out,
  output logic             frame_pulse_pin_oe_b,
  input  wire logic        serial_tx_data_in,
  input  wire logic        line_rx_clock,
  input  wire logic        line_rx_data,
  output logic             extracted_clock_out,
  output logic             serial_rx_data_out,
  output logic             tx_line_clock,
  output logic             tx_line_data,
  output logic             slip_buffer_enable,
  output logic             sig_hdlc_enable
);
  import ja_clock_pkg::*;

  function automatic logic [8:0] depth_bits(input logic [2:0] sel);
    // widen before adding: the deepest setting would wrap to zero in three bits
    depth_bits = {({1'b0, sel} + 4'h1), 5'h00};
  endfunction

  // pin synchronisers: {bs, sfr, sysclk, frame, txd, lineclk, linedata}
  logic [6:0] pin_s1_q;
  logic [6:0] pin_s2_q;
  logic [6:0] pin_s3_q;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_q <= 7'h00;
      pin_s2_q <= 7'h00;
      pin_s3_q <= 7'h00;
    end else begin
      pin_s1_q <= {bus_or_line_select, sync_or_freerun_select, system_clock_pin_in,
                   frame_pulse_pin_in, serial_tx_data_in, line_rx_clock, line_rx_data};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end
  logic sysclk_rise;
  logic line_rise;
  logic frame_fall;
  assign sysclk_rise = pin_s2_q[4] & ~pin_s3_q[4];
  assign frame_fall  = ~pin_s2_q[3] & pin_s3_q[3];
  assign line_rise   = pin_s2_q[1] & ~pin_s3_q[1];

  // mode decode
  clk_mode_t mode;
  always_comb begin
    if (!pin_s2_q[5])
      mode = MODE_FREE; // see [RL1]
    else if (pin_s2_q[6])
      mode = MODE_SYSBUS; // see [RL1]
    else
      mode = MODE_LINE; // see [RL1]
  end

  // control register
  logic       e1_mode_q;
  logic       ima_mode_q;
  logic [2:0] depth_sel_q;
  logic       center_tog_q;
  logic       center_prev_q;
  logic       bus_wr;
  assign bus_wr = avs_write & ~avs_waitrequest;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      e1_mode_q    <= 1'b0;
      ima_mode_q   <= 1'b0;
      depth_sel_q  <= DEPTH_SEL_RST; // see [RL21]
      center_tog_q <= 1'b0;
    end else if (bus_wr && avs_address == ADDR_CTRL) begin
      e1_mode_q    <= avs_writedata[CTRL_E1];
      ima_mode_q   <= avs_writedata[CTRL_IMA];
      depth_sel_q  <= avs_writedata[CTRL_DEPTH_LO +: 3]; // see [RL11]
      center_tog_q <= avs_writedata[CTRL_CENTER];
    end
  end

  // inverse mux routing is honoured only in system-bus mode; sig_hdlc_enable follows ima_mode_q in any mode
  logic fifo_path;
  assign fifo_path = (mode == MODE_SYSBUS) & (e1_mode_q | ima_mode_q); // see [RL8] [RL9] [RL19]
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      slip_buffer_enable <= 1'b0;
      sig_hdlc_enable    <= 1'b1;
    end else begin
      slip_buffer_enable <= (mode == MODE_SYSBUS) & ~e1_mode_q & ~ima_mode_q; // see [RL7] [RL15]
      sig_hdlc_enable    <= ~ima_mode_q; // see [RL15]
    end
  end

  // re-centring window
  logic [8:0]  level;
  logic [14:0] center_cnt_q;
  logic        centering_q;
  logic        center_req;
  assign center_req = center_tog_q ^ center_prev_q;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      center_prev_q <= 1'b0;
      center_cnt_q  <= 15'h0000;
      centering_q   <= 1'b0;
    end else begin
      center_prev_q <= center_tog_q;
      if (center_req) begin
        centering_q  <= 1'b1; // see [RL12]
        center_cnt_q <= 15'(CENTER_CYC_PER_WORD * ({3'h0, depth_sel_q} + 6'h01) * 16); // see [RL14]
      end else if (centering_q) begin
        if (center_cnt_q <= 15'h0001)
          centering_q <= 1'b0;
        center_cnt_q <= center_cnt_q - 15'h0001;
      end
    end
  end

  // reference period measurement, fixed point x16
  logic        ref_edge;
  logic [7:0]  meas_q;
  logic [11:0] per_q;
  logic signed [12:0] per_diff;
  assign ref_edge = (mode == MODE_SYSBUS) ? sysclk_rise : line_rise; // see [RL20]
  // signed error so the filter can pull the period both ways
  assign per_diff = $signed({1'b0, meas_q, 4'h0}) - $signed({1'b0, per_q});
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      meas_q <= 8'h00;
      per_q  <= FREE_PER_X16;
    end else if (mode == MODE_FREE) begin
      meas_q <= 8'h00;
      per_q  <= FREE_PER_X16; // see [RL6]
    end else if (ref_edge) begin
      meas_q <= 8'h01;
      if (centering_q)
        per_q <= {meas_q, 4'h0}; // raw tracking while centring, see [RL14]
      else
        per_q <= per_q + 12'(per_diff >>> 4); // see [RL3] [RL4]
    end else if (meas_q != 8'hff) begin
      meas_q <= meas_q + 8'h01;
    end
  end

  // pointer near an end nudges the read rate by a sixteenth
  logic        near_empty;
  logic        near_full;
  logic [11:0] eff_per;
  assign near_empty = fifo_path & (level <= EDGE_GUARD);
  assign near_full  = fifo_path & (level >= depth_bits(depth_sel_q) - EDGE_GUARD);
  always_comb begin
    eff_per = per_q;
    if (near_empty)
      eff_per = per_q + (per_q >> 4); // see [RL13]
    else if (near_full)
      eff_per = per_q - (per_q >> 4); // see [RL13]
  end

  // clean clock oscillator
  logic [11:0] acc_q;
  logic        tick;
  logic [11:0] acc_nx;
  assign acc_nx = acc_q + 12'h010;
  assign tick   = acc_nx >= eff_per;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b)
      acc_q <= 12'h000;
    else if (tick)
      acc_q <= acc_nx - eff_per;
    else
      acc_q <= acc_nx;
  end

  // FIFO of single bits, sized for the deepest setting
  logic [ARRAY_BITS-1:0] fifo_mem_q;
  // one spare pointer bit so a full deepest fifo is not read as empty
  logic [8:0]            wr_ptr_q;
  logic [8:0]            rd_ptr_q;
  logic                  fifo_wr;
  logic                  fifo_rd;
  logic [8:0]            depth_now;
  logic [8:0]            half_depth;
  assign depth_now  = depth_bits(depth_sel_q);
  assign half_depth = {1'b0, depth_now[8:1]};
  assign level   = wr_ptr_q - rd_ptr_q;
  assign fifo_wr = fifo_path & sysclk_rise & (level < depth_bits(depth_sel_q)); // see [RL10] [RL16] [RL17]
  assign fifo_rd = fifo_path & tick & (level != 9'h000); // see [RL10]
  always_ff @(posedge clk_sys) begin
    if (fifo_wr)
      fifo_mem_q[wr_ptr_q[7:0]] <= pin_s2_q[2];
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_q <= 9'h000;
      rd_ptr_q <= 9'h000;
    end else begin
      if (fifo_wr)
        wr_ptr_q <= wr_ptr_q + 9'h001;
      if (center_req)
        rd_ptr_q <= wr_ptr_q - half_depth; // see [RL12]
      else if (fifo_rd)
        rd_ptr_q <= rd_ptr_q + 9'h001;
    end
  end

  // transmit side and clock pin outputs
  logic       slip_bit_q;
  logic [9:0] frame_cnt_q;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      slip_bit_q    <= 1'b0;
      tx_line_data  <= 1'b0;
      tx_line_clock <= 1'b0;
    end else begin
      tx_line_clock <= acc_q < (eff_per >> 1); // see [RL3] [RL4] [RL6]
      if (sysclk_rise)
        slip_bit_q <= pin_s2_q[2];
      if (tick) begin
        if (fifo_path)
          tx_line_data <= fifo_mem_q[rd_ptr_q[7:0]]; // see [RL8] [RL9]
        else if (mode == MODE_SYSBUS)
          tx_line_data <= slip_bit_q; // see [RL7]
        else
          tx_line_data <= pin_s2_q[2]; // see [RL4] [RL6]
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b)
      frame_cnt_q <= 10'h000;
    else if (mode == MODE_SYSBUS && frame_fall)
      frame_cnt_q <= 10'h000;
    else if (tick)
      frame_cnt_q <= (frame_cnt_q == 10'(FRAME_TICKS - 1)) ? 10'h000 : frame_cnt_q + 10'h001;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      system_clock_pin_oe_b <= 1'b1;
      frame_pulse_pin_oe_b  <= 1'b1;
      system_clock_pin_out  <= 1'b1;
      frame_pulse_pin_out   <= 1'b1;
    end else begin
      system_clock_pin_oe_b <= mode == MODE_SYSBUS; // see [RL2]
      frame_pulse_pin_oe_b  <= mode == MODE_SYSBUS; // see [RL2]
      system_clock_pin_out  <= ~(acc_q < (eff_per >> 1)); // see [RL4] [RL6]
      frame_pulse_pin_out   <= frame_cnt_q != 10'h000;
    end
  end

  // raw recovered clock and data straight to the outputs
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      extracted_clock_out <= 1'b0;
      serial_rx_data_out  <= 1'b0;
    end else begin
      extracted_clock_out <= pin_s2_q[1]; // see [RL5] [RL18]
      serial_rx_data_out  <= pin_s2_q[0]; // see [RL18]
    end
  end

  // Avalon-MM slave: one wait cycle on every access
  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_MODE_LO +: 3]   = mode;
    status_word[ST_CENTERING]      = centering_q;
    status_word[ST_FIFO_PATH]      = fifo_path;
    status_word[ST_SLIP_ON]        = slip_buffer_enable;
    status_word[ST_LEVEL_LO +: 9]  = level;
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      case (avs_address)
        ADDR_CTRL:   avs_readdata <= {26'h0, center_tog_q, depth_sel_q, ima_mode_q, e1_mode_q};
        ADDR_STATUS: avs_readdata <= status_word;
        default:     avs_readdata <= 32'h0000_0000;
      endcase
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  AST_MODE_FREE: assert property ( // see [RL1]
    !pin_s2_q[5] |-> mode == MODE_FREE) else $error("free-run not chosen");
  AST_PIN_DIR: assert property ( // see [RL2]
    (mode == MODE_SYSBUS) |=> system_clock_pin_oe_b && frame_pulse_pin_oe_b)
    else $error("clock pins driven in system-bus mode");
  AST_PIN_DRIVE: assert property ( // see [RL2]
    (mode != MODE_SYSBUS) |=> !system_clock_pin_oe_b) else $error("clock pin not driven");
  AST_EXCLK_RAW: assert property ( // see [RL5]
    extracted_clock_out == $past(pin_s2_q[1])) else $error("extracted clock not raw");
  AST_SLIP_T1: assert property ( // see [RL7]
    (mode == MODE_SYSBUS && !e1_mode_q && !ima_mode_q) |=> slip_buffer_enable)
    else $error("slip buffer off in normal T1");
  AST_NO_SLIP_IMA: assert property ( // see [RL15]
    ima_mode_q |=> !slip_buffer_enable && !sig_hdlc_enable) else $error("ima features on");
  AST_DEPTH_BOUND: assert property ( // see [RL11]
    level <= depth_bits(depth_sel_q) || $changed(depth_sel_q) || center_req
      || $past(center_req)) else $error("fifo over depth");
  AST_RECENTER: assert property ( // see [RL12]
    center_req |=> centering_q && (level == half_depth || level == half_depth + 9'h001))
    else $error("read pointer not centred");
  AST_NUDGE: assert property ( // see [RL13]
    near_empty |-> eff_per == per_q + (per_q >> 4)) else $error("no slow down near empty");
  AST_FREE_PER: assert property ( // see [RL6]
    (mode == MODE_FREE) [*2] |-> per_q == FREE_PER_X16) else $error("free-run period off");
  AST_RX_DATA: assert property ( // see [RL18]
    serial_rx_data_out == $past(pin_s2_q[0])) else $error("rx data not passed through");

  COV_CENTER: cover property (center_req ##1 centering_q);
  COV_FIFO_RD: cover property (fifo_wr ##[1:40] fifo_rd);
  COV_LINE: cover property (mode == MODE_LINE ##1 !system_clock_pin_oe_b);
  COV_NEAR_FULL: cover property (near_full);
endmodule
`default_nettype wire

/* File: bench/backplane_source.sv */
// backplane timing source: system clock, frame pulse, serial data, line clock
// assumes the bench resolves the two-way pins from the block's enables
`default_nettype none
module backplane_source #(
  parameter int unsigned HALF_NS = 100
) (
  input  wire logic run,
  output logic      sys_clk,
  output logic      frame_b,
  output logic      tx_data,
  output logic      line_clk,
  output logic      line_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] tick_q;
  initial begin
    sys_clk   = 1'b0;
    frame_b   = 1'b1;
    tx_data   = 1'b0;
    tick_q    = 4'h0;
    line_clk  = 1'b0;
    line_data = 1'b0;
  end
  // write clock of the fifo; stands still while not running
  always begin
    #(HALF_NS);
    if (run) begin
      sys_clk = ~sys_clk;
    end
  end
  // data and frame change on the falling clock edge, far from the rise that samples them
  always @(negedge sys_clk) begin
    tick_q  <= tick_q + 4'h1;
    frame_b <= (tick_q != 4'hf);
    tx_data <= tick_q[0] ^ tick_q[2];
  end
  // recovered line clock, odd phase against the system clock
  initial begin
    #37;
    forever begin
      #(HALF_NS + 3) line_clk = ~line_clk;
    end
  end
  always @(negedge line_clk) begin
    line_data <= ~line_data ^ tick_q[1];
  end
endmodule
`default_nettype wire

/* File: bench/test_jitter_attenuation_clock_mode.sv */
// bench: register, mode pin, routing and centring tests of the clock mode block
// assumes the avalon slave answers after one cycle and a 40 MHz clock
`default_nettype none
module test_jitter_attenuation_clock_mode;
  timeunit 1ns;
  timeprecision 100ps;
  import ja_clock_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  address = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic        waitreq;
  logic        bls = 1'b1;
  logic        sfs = 1'b1;
  logic        run = 1'b1;
  logic        p_clk, p_frm, p_dat, l_clk, l_dat;
  logic        c_out, c_oe_b, f_out, f_oe_b, ext_clk, rx_out, tx_clk, tx_dat, slip, sighd;
  logic        c_wire, f_wire;
  logic [2:0]  clk_hist_q, dat_hist_q;
  logic [31:0] v;
  int          fails = 0;
  int          compares = 0;
  int          n;
  always #12.5 clk_sys = ~clk_sys;
  assign c_wire = c_oe_b ? p_clk : c_out;
  assign f_wire = f_oe_b ? p_frm : f_out;
  always_ff @(posedge clk_sys) begin
    clk_hist_q <= {clk_hist_q[1:0], l_clk};
    dat_hist_q <= {dat_hist_q[1:0], l_dat};
  end
  backplane_source src (.run(run), .sys_clk(p_clk), .frame_b(p_frm), .tx_data(p_dat),
                        .line_clk(l_clk), .line_data(l_dat));
  ja_clock_mode #(.CENTER_CYC_PER_WORD(2), .FRAME_TICKS(16)) dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .avs_address(address), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdata), .avs_readdata(rdata),
    .avs_waitrequest(waitreq), .bus_or_line_select(bls), .sync_or_freerun_select(sfs),
    .system_clock_pin_in(c_wire), .system_clock_pin_out(c_out),
    .system_clock_pin_oe_b(c_oe_b), .frame_pulse_pin_in(f_wire),
    .frame_pulse_pin_out(f_out), .frame_pulse_pin_oe_b(f_oe_b),
    .serial_tx_data_in(p_dat), .line_rx_clock(l_clk), .line_rx_data(l_dat),
    .extracted_clock_out(ext_clk), .serial_rx_data_out(rx_out), .tx_line_clock(tx_clk),
    .tx_line_data(tx_dat), .slip_buffer_enable(slip), .sig_hdlc_enable(sighd));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // one access; a slave that never answers is left to the watchdog
  task automatic access(input logic wnr, input logic [3:0] a, input logic [31:0] d,
                        output logic [31:0] q);
    @(posedge clk_sys);
    address <= a;
    wdata   <= d;
    wr      <= wnr;
    rd      <= ~wnr;
    do @(posedge clk_sys); while (waitreq !== 1'b0);
    q  = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic set_pins(input logic b, input logic s);
    @(posedge clk_sys);
    bls <= b;
    sfs <= s;
    repeat (6) @(posedge clk_sys);
  endtask
  // counts level changes of the clock pin driver and the transmit clock
  task automatic toggles(input int cyc, output int cnt);
    logic lc, lt;
    cnt = 0;
    lc = c_out;
    lt = tx_clk;
    repeat (cyc) begin
      @(negedge clk_sys);
      cnt += (c_out != lc) + (tx_clk != lt);
      lc = c_out;
      lt = tx_clk;
    end
  endtask
  initial begin
    #(25 * 40000);
    fails++;
    summarize();
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(negedge clk_sys);
    check(waitreq, 1'b1);
    check({c_oe_b, f_oe_b}, 2'b11);
    access(1'b0, ADDR_CTRL, 32'h0, v);
    check(v, 32'h1c);
    access(1'b0, 4'h8, 32'h0, v);
    check(v, 32'h0);
    $display("test reset done");
    // mode pin table and pin directions
    for (int i = 0; i < 4; i++) begin
      set_pins(i[1], i[0]);
      access(1'b0, ADDR_STATUS, 32'h0, v);
      check(v[2:0], (i == 3) ? 3'b001 : (i == 1) ? 3'b010 : 3'b100);
      check({c_oe_b, f_oe_b}, (i == 3) ? 2'b11 : 2'b00);
    end
    $display("test modes done");
    // free-run: internal clock about 4.096 MHz on pin and transmit clock
    set_pins(1'b0, 1'b0);
    toggles(400, n);
    check(n >= 140 && n <= 180, 1'b1);
    set_pins(1'b0, 1'b1);
    // line clock of 206 ns: about 388 level changes on the two outputs after lock-in
    toggles(800, n);
    check(n >= 340 && n <= 400, 1'b1);
    $display("test clocks done");
    // line clock and data go out raw in every mode
    for (int m = 0; m < 3; m++) begin
      set_pins(m == 0, m != 2);
      repeat (24) begin
        @(negedge clk_sys);
        check(ext_clk, clk_hist_q[2]);
        check(rx_out, dat_hist_q[2]);
      end
    end
    $display("test extracted done");
    // path choice in system-bus mode for each e1 / ima pair
    set_pins(1'b1, 1'b1);
    for (int k = 0; k < 4; k++) begin
      access(1'b1, ADDR_CTRL, 32'h1c | k, v);
      access(1'b0, ADDR_STATUS, 32'h0, v);
      check(v[ST_FIFO_PATH], k != 0);
      check(slip, k == 0);
      check(sighd, k[1] == 1'b0);
    end
    set_pins(1'b0, 1'b1);
    check(slip, 1'b0);
    $display("test paths done");
    // centring at the smallest depth, then fifo level stays inside it
    set_pins(1'b1, 1'b1);
    access(1'b1, 4'h8, 32'hffff, v);
    access(1'b1, ADDR_CTRL, 32'h21, v);
    access(1'b0, ADDR_CTRL, 32'h0, v);
    check(v, 32'h21);
    access(1'b0, ADDR_STATUS, 32'h0, v);
    check(v[ST_CENTERING], 1'b1);
    repeat (2 * 16 + 8) @(posedge clk_sys);
    access(1'b0, ADDR_STATUS, 32'h0, v);
    check(v[ST_CENTERING], 1'b0);
    repeat (3000) @(posedge clk_sys);
    access(1'b0, ADDR_STATUS, 32'h0, v);
    check(v[16:8] <= 9'd32 && v[16:8] != 9'd0, 1'b1);
    access(1'b1, ADDR_CTRL, 32'h01, v);
    access(1'b0, ADDR_STATUS, 32'h0, v);
    check(v[ST_CENTERING], 1'b1);
    $display("test centring done");
    summarize();
  end
endmodule
`default_nettype wire
